// ---- core/tfx_pkg.sv ----
// Constants, command word layout and state codes for the transmit frame
// FIFO extractor. Assumes one 40 MHz clock and 32-bit little-endian words.
//
// Overview of operation
// R1: Writer stores length word before command words
// R2: Host buffer opens with command A, B
// R3: IGMP sum request ignored under segmentation
// R4: ICMP sum request ignored under segmentation
// R5: Bit 27 enables segmentation, size from B
// R6: IP header sum ignored under segmentation
// R7: TCP/UDP sum ignored under segmentation
// R8: Bit 24 inserts tag from B[15:0]
// R9: Bit 23 replaces tag, else stacks second
// R10: Bit 22 asks FCS and zero pad
// R11: Host: offloads need FCS-and-pad bit set; the code does not check it
// R12: A[19:0] is frame or packet length
// R13: Host: no-FCS frames at least 32 bytes
// R14: B[29:16] is 14-bit segment size
// R15: Host: segment size never below 8
// R16: Tag splits priority, CFI, VLAN identifier
// R17: Data follows B; trailing bytes never forwarded
// R18: Strip header words, trim enables, sideband options
// R19: Retry request rewinds read to buffer start
// R20: Release request frees buffer, advances pointers
// R21: Bad command fields make path out of sync
// R22: Reserved A[31:30] nonzero raises error flag
// R23: Replace without insert raises error flag
// R24: Length word low bits hold frame length
`default_nettype none
package tfx_pkg;
  // ******************************************************
  // Storage
  // ******************************************************
  localparam int unsigned FIFO_WORDS = 3072; // 12 KB of 32-bit words
  localparam int PTR_W = 12;
  localparam logic [PTR_W-1:0] RDY_MARGIN = 12'h004; // Covers registered ready lag
  // ******************************************************
  // Command word A and B fields
  // ******************************************************
  localparam int A_IGMP = 29;
  localparam int A_ICMP = 28;
  localparam int A_SEG = 27;
  localparam int A_IPH = 26;
  localparam int A_L4 = 25;
  localparam int A_TAGINS = 24;
  localparam int A_TAGREP = 23;
  localparam int A_FCS = 22;
  localparam int LEN_MSB = 19;
  localparam int LEN_HI_LSB = 16; // Upper nibble, legal only for segmentation
  localparam int MSS_MSB = 29;
  localparam int MSS_LSB = 16;
  localparam int TAG_MSB = 15;
  localparam int PRI_LSB = 13;
  localparam int CFI_BIT = 12;
  localparam int VID_MSB = 11;
  localparam logic [19:0] MIN_NOFCS_LEN = 20'h00020; // 32 bytes
  localparam logic [19:0] MAX_PLAIN_LEN = 20'h02ff7;
  localparam logic [13:0] MIN_MSS = 14'h0008;
  localparam int LW_CNT_LSB = 20; // Word count kept above the length
  // ******************************************************
  // Register map (byte offsets) and bits
  // ******************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LEVEL = 4'h8;
  localparam logic [3:0] REG_CAUSE = 4'hc;
  localparam int CTRL_RD_EN = 0;
  localparam int CTRL_REINIT = 1;
  localparam int STS_OOS = 0;
  localparam int STS_TXE = 1;
  // ******************************************************
  // States
  // ******************************************************
  typedef enum logic [2:0] {
    W_IDLE = 3'b001, W_BODY = 3'b010, W_COMMIT = 3'b100
  } tfx_wst_t;
  typedef enum logic [6:0] {
    R_IDLE = 7'b0000001, R_LEN = 7'b0000010, R_CMDA = 7'b0000100,
    R_CMDB = 7'b0001000, R_DATA = 7'b0010000, R_HOLD = 7'b0100000,
    R_HALT = 7'b1000000
  } tfx_rst_t;
endpackage : tfx_pkg
`default_nettype wire

// ---- core/tfx_ram_if.sv ----
// Port bundle between the extractor control and its word store.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface tfx_ram_if;
  logic wr_en; // Write strobe
  logic [11:0] wr_addr; // Write word address
  logic [31:0] wr_data; // Write word
  logic [11:0] rd_addr; // Read word address
  logic [31:0] rd_data; // Word at rd_addr, same cycle
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : tfx_ram_if
`default_nettype wire

// ---- core/tfx_ram.sv ----
// Word store of the transmit FIFO: one write port, one unregistered read.
// Assumes the controller never reads an address in the cycle it writes it.
`timescale 1ns/1ps
`default_nettype none
module tfx_ram
  import tfx_pkg::*;
(
  input wire logic clk,
  tfx_ram_if.mem port
);
  // ******************************************************
  // Storage array
  // ******************************************************
  logic [31:0] mem [FIFO_WORDS]; // Frame buffers, no reset needed
  // Write port
  always_ff @(posedge clk)
  begin
    if (port.wr_en)
    begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end
  // Read is combinational so the parser sees a word per cycle
  assign port.rd_data = mem[port.rd_addr];
endmodule : tfx_ram
`default_nettype wire

// ---- core/tfx_top.sv ----
// Transmit frame FIFO extractor: stores host buffers, parses command
// words and streams frame data to the MAC. Assumes one clock, a MAC that
// answers each frame with one retry or one release pulse.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tfx_top
  import tfx_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_valid,
  input wire logic wr_first,
  input wire logic wr_last,
  input wire logic [31:0] wr_data,
  output logic wr_ready,
  output logic mac_valid,
  output logic [31:0] mac_data,
  output logic [3:0] mac_be,
  output logic mac_last,
  input wire logic mac_ready,
  input wire logic collision_retry_request,
  input wire logic frame_done_release,
  output logic opt_valid,
  output logic igmp_sum_enable,
  output logic icmp_sum_enable,
  output logic segmentation_offload_enable,
  output logic ip_header_sum_enable,
  output logic l4_sum_enable,
  output logic tag_insert_enable,
  output logic tag_replace_enable,
  output logic fcs_pad_enable,
  output logic [19:0] frame_length_field,
  output logic [13:0] max_segment_size,
  output logic [2:0] tag_priority,
  output logic tag_cfi,
  output logic [11:0] tag_vlan_id,
  output logic transmitter_error_flag,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // ******************************************************
  // Helpers
  // ******************************************************
  // Circular pointer advance
  function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] p,
                                               input logic [PTR_W-1:0] n);
    logic [PTR_W:0] s;
    s = {1'b0, p} + {1'b0, n};
    if (s >= (PTR_W+1)'(FIFO_WORDS))
    begin
      s = s - (PTR_W+1)'(FIFO_WORDS);
    end
    return s[PTR_W-1:0];
  endfunction : ptr_add
  // Words from b up to a around the ring
  function automatic logic [PTR_W-1:0] ptr_dist(input logic [PTR_W-1:0] a,
                                                input logic [PTR_W-1:0] b);
    logic [PTR_W:0] d;
    d = {1'b0, a} - {1'b0, b};
    if (a < b)
    begin
      d = d + (PTR_W+1)'(FIFO_WORDS);
    end
    return d[PTR_W-1:0];
  endfunction : ptr_dist
  // Byte enables for a word with rem bytes still owed
  function automatic logic [3:0] be_for(input logic [19:0] rem);
    if (rem >= 20'h00004)
    begin
      return 4'hf;
    end
    unique case (rem[1:0])
      2'h1: return 4'h1;
      2'h2: return 4'h3;
      2'h3: return 4'h7;
      default: return 4'h0;
    endcase
  endfunction : be_for

  tfx_ram_if ram ();
  tfx_ram u_ram (.clk(clk), .port(ram));

  // ******************************************************
  // State
  // ******************************************************
  tfx_wst_t wst_reg, wst_next; // Writer state
  tfx_rst_t rst_reg; // Parser state
  logic [PTR_W-1:0] wr_ptr_reg; // Next free slot
  logic [PTR_W-1:0] head_reg; // Slot held for the length word
  logic [PTR_W-1:0] commit_reg; // End of last complete buffer
  logic [PTR_W-1:0] rd_ptr_reg; // Parser read slot
  logic [PTR_W-1:0] start_reg; // First slot of the oldest buffer
  logic [11:0] cnt_reg; // Words of the buffer being written
  logic [19:0] wlen_reg; // Length from command A, write side
  logic [31:0] lw_reg; // Length word read back
  logic [31:0] cmda_reg; // Command A read back
  logic [19:0] left_reg; // Bytes still to hand to the MAC
  logic ctrl_rd_en_reg; // Software gate for the parser
  logic oos_reg; // Path out of sync, parser halted
  logic [8:0] cause_reg; // Which check failed
  // ******************************************************
  // Decode
  // ******************************************************
  wire reinit = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_REINIT];
  wire w_take = wr_valid && wr_ready && (wst_reg != W_COMMIT);
  wire w_start = w_take && wst_reg == W_IDLE && wr_first;
  wire [PTR_W-1:0] w_free = 12'(FIFO_WORDS - 1) - ptr_dist(wr_ptr_reg, start_reg);
  wire [31:0] rd_word = ram.rd_data;
  wire out_free = !mac_valid || mac_ready;
  wire seg = cmda_reg[A_SEG];
  wire [13:0] mss = rd_word[MSS_MSB:MSS_LSB];
  wire [19:0] alen = cmda_reg[LEN_MSB:0];
  // Sanity checks on the command pair, evaluated as B arrives
  wire [8:0] chk = {
    cmda_reg[31:30] != 2'h0,                                // see R22
    cmda_reg[A_TAGREP] && !cmda_reg[A_TAGINS],              // see R23
    cmda_reg[21:20] != 2'h0,                                // see R21
    rd_word[31:30] != 2'h0,
    seg ? (mss < MIN_MSS) : (mss != 14'h0000),
    !seg && cmda_reg[LEN_MSB:LEN_HI_LSB] != 4'h0,
    !seg && alen > MAX_PLAIN_LEN,
    !cmda_reg[A_FCS] && alen < MIN_NOFCS_LEN,
    1'b0};
  wire chk_fail = rst_reg == R_CMDB && chk != 9'h000; // see R21
  wire rel = frame_done_release && (rst_reg == R_DATA || rst_reg == R_HOLD);
  wire rew = collision_retry_request && (rst_reg == R_DATA || rst_reg == R_HOLD);
  wire emit = rst_reg == R_DATA && out_free && !rel && !rew;
  wire emit_last = left_reg <= 20'h00004; // see R17
  // Buffer end: length slot plus the stored word count
  wire [PTR_W-1:0] rel_ptr = ptr_add(start_reg, 12'(lw_reg[31:LW_CNT_LSB] + 12'h001)); // see R20

  // ******************************************************
  // Writer: reserve a length slot, store words, then commit
  // ******************************************************
  always_comb
  begin
    wst_next = wst_reg;
    unique case (wst_reg)
      W_IDLE: if (w_start) wst_next = W_BODY;
      W_BODY: if (w_take && wr_last) wst_next = W_COMMIT;
      W_COMMIT: wst_next = W_IDLE;
    endcase
  end
  assign ram.wr_en = (wst_reg == W_COMMIT) || w_start || (w_take && wst_reg == W_BODY);
  // First word lands one past the held slot
  assign ram.wr_addr = (wst_reg == W_COMMIT) ? head_reg :
                       (wst_reg == W_IDLE) ? ptr_add(wr_ptr_reg, 12'h001) : wr_ptr_reg; // see R1
  assign ram.wr_data = (wst_reg == W_COMMIT) ?
                       {cnt_reg, wlen_reg} : wr_data; // see R24
  assign ram.rd_addr = rd_ptr_reg;

  // Writer pointers; commit publishes the buffer to the parser
  always_ff @(posedge clk)
  begin
    if (reset || reinit)
    begin
      wst_reg <= W_IDLE;
      wr_ptr_reg <= 12'h000;
      head_reg <= 12'h000;
      commit_reg <= 12'h000;
      cnt_reg <= 12'h000;
      wlen_reg <= 20'h00000;
    end
    else
    begin
      wst_reg <= wst_next;
      if (w_start)
      begin
        head_reg <= wr_ptr_reg;
        wr_ptr_reg <= ptr_add(wr_ptr_reg, 12'h002);
        cnt_reg <= 12'h001;
        wlen_reg <= wr_data[LEN_MSB:0]; // see R12
      end
      else if (w_take && wst_reg == W_BODY)
      begin
        wr_ptr_reg <= ptr_add(wr_ptr_reg, 12'h001);
        cnt_reg <= cnt_reg + 12'h001;
      end
      if (wst_reg == W_COMMIT)
      begin
        commit_reg <= wr_ptr_reg; // see R1
      end
    end
  end
  // Registered ready keeps a margin since it lags the pointer by a cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ready <= 1'b0;
    end
    else
    begin
      wr_ready <= (w_free > RDY_MARGIN) && (wst_next != W_COMMIT);
    end
  end

  // ******************************************************
  // Parser: length, A, B, data, then wait for the MAC verdict
  // ******************************************************
  always_ff @(posedge clk)
  begin
    if (reset || reinit)
    begin
      rst_reg <= R_IDLE;
      rd_ptr_reg <= 12'h000;
      start_reg <= 12'h000;
      lw_reg <= 32'h0000_0000;
      cmda_reg <= 32'h0000_0000;
      left_reg <= 20'h00000;
    end
    else
    begin
      unique case (rst_reg)
        R_IDLE:
        begin
          // Only committed buffers are parsed
          if (ctrl_rd_en_reg && commit_reg != rd_ptr_reg) rst_reg <= R_LEN;
        end
        R_LEN:
        begin
          lw_reg <= rd_word; // see R18
          rd_ptr_reg <= ptr_add(rd_ptr_reg, 12'h001);
          rst_reg <= R_CMDA;
        end
        R_CMDA:
        begin
          cmda_reg <= rd_word; // see R18
          rd_ptr_reg <= ptr_add(rd_ptr_reg, 12'h001);
          rst_reg <= R_CMDB;
        end
        R_CMDB:
        begin
          rd_ptr_reg <= ptr_add(rd_ptr_reg, 12'h001);
          left_reg <= lw_reg[LEN_MSB:0];
          if (chk_fail) rst_reg <= R_HALT; // see R21
          else if (lw_reg[LEN_MSB:0] == 20'h00000) rst_reg <= R_HOLD;
          else rst_reg <= R_DATA;
        end
        R_DATA, R_HOLD:
        begin
          if (rel)
          begin
            start_reg <= rel_ptr; // see R20
            rd_ptr_reg <= rel_ptr;
            rst_reg <= R_IDLE;
          end
          else if (rew)
          begin
            rd_ptr_reg <= start_reg; // see R19
            rst_reg <= R_IDLE;
          end
          else if (emit)
          begin
            rd_ptr_reg <= ptr_add(rd_ptr_reg, 12'h001);
            left_reg <= emit_last ? 20'h00000 : left_reg - 20'h00004;
            if (emit_last) rst_reg <= R_HOLD; // see R17
          end
        end
        R_HALT: rst_reg <= R_HALT; // Fatal until reinitialised
      endcase
    end
  end

  // MAC data stage; a rewind or release drops any word in flight
  always_ff @(posedge clk)
  begin
    if (reset || reinit)
    begin
      mac_valid <= 1'b0;
      mac_data <= 32'h0000_0000;
      mac_be <= 4'h0;
      mac_last <= 1'b0;
    end
    else if (rel || rew)
    begin
      mac_valid <= 1'b0;
    end
    else if (emit)
    begin
      mac_valid <= 1'b1;
      mac_data <= rd_word;
      mac_be <= be_for(left_reg); // see R18
      mac_last <= emit_last;
    end
    else if (mac_ready)
    begin
      mac_valid <= 1'b0;
    end
  end

  // Sideband options, held from command B until the verdict
  always_ff @(posedge clk)
  begin
    if (reset || reinit)
    begin
      opt_valid <= 1'b0;
      {igmp_sum_enable, icmp_sum_enable, segmentation_offload_enable} <= 3'h0;
      {ip_header_sum_enable, l4_sum_enable, fcs_pad_enable} <= 3'h0;
      {tag_insert_enable, tag_replace_enable} <= 2'h0;
      frame_length_field <= 20'h00000;
      max_segment_size <= 14'h0000;
      {tag_priority, tag_cfi, tag_vlan_id} <= 16'h0000;
    end
    else if (rst_reg == R_CMDB && !chk_fail)
    begin
      opt_valid <= 1'b1;
      // Checksum requests mean nothing while segmenting
      igmp_sum_enable <= cmda_reg[A_IGMP] && !seg; // see R3
      icmp_sum_enable <= cmda_reg[A_ICMP] && !seg; // see R4
      segmentation_offload_enable <= seg; // see R5
      ip_header_sum_enable <= cmda_reg[A_IPH] && !seg; // see R6
      l4_sum_enable <= cmda_reg[A_L4] && !seg; // see R7
      tag_insert_enable <= cmda_reg[A_TAGINS]; // see R8
      tag_replace_enable <= cmda_reg[A_TAGREP]; // see R9
      fcs_pad_enable <= cmda_reg[A_FCS]; // see R10
      frame_length_field <= alen; // see R12
      max_segment_size <= seg ? mss : 14'h0000; // see R14
      tag_priority <= rd_word[TAG_MSB:PRI_LSB]; // see R16
      tag_cfi <= rd_word[CFI_BIT];
      tag_vlan_id <= rd_word[VID_MSB:0];
    end
    else if (rel || rew)
    begin
      opt_valid <= 1'b0;
    end
  end

  // ******************************************************
  // Registers and error flag
  // ******************************************************
  // Error flag: a new failure beats a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_rd_en_reg <= 1'b0;
      oos_reg <= 1'b0;
      transmitter_error_flag <= 1'b0;
      cause_reg <= 9'h000;
    end
    else
    begin
      if (reg_wr && reg_addr == REG_CTRL) ctrl_rd_en_reg <= reg_wdata[CTRL_RD_EN];
      if (chk_fail)
      begin
        oos_reg <= 1'b1; // see R21
        transmitter_error_flag <= 1'b1; // see R22 see R23
        cause_reg <= chk;
      end
      else
      begin
        if (reinit) oos_reg <= 1'b0;
        if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STS_TXE])
          transmitter_error_flag <= 1'b0;
      end
    end
  end
  // Read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          REG_CTRL: reg_rdata <= {31'h0, ctrl_rd_en_reg};
          REG_STATUS: reg_rdata <= {30'h0, transmitter_error_flag, oos_reg};
          REG_LEVEL: reg_rdata <= {20'h0, ptr_dist(commit_reg, start_reg)};
          REG_CAUSE: reg_rdata <= {23'h0, cause_reg};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ******************************************************
  // Checks
  // ******************************************************
  a_len_slot_write: assert property (@(posedge clk) disable iff (reset) // see R1
    wst_reg == W_COMMIT |-> ram.wr_en && ram.wr_addr == head_reg
      && ram.wr_data[LEN_MSB:0] == wlen_reg)
    else $error("length word not written to held slot");
  a_seg_gates_sums: assert property (@(posedge clk) disable iff (reset) // see R3
    opt_valid && segmentation_offload_enable |-> !(igmp_sum_enable || icmp_sum_enable
      || ip_header_sum_enable || l4_sum_enable))
    else $error("checksum request passed while segmenting");
  a_tag_from_b: assert property (@(posedge clk) disable iff (reset || reinit) // see R8
    rst_reg == R_CMDB && !chk_fail |=> opt_valid
      && {tag_priority, tag_cfi, tag_vlan_id} == $past(rd_word[TAG_MSB:0]))
    else $error("tag sideband does not match command B");
  a_full_be_mid: assert property (@(posedge clk) disable iff (reset) // see R18
    mac_valid && !mac_last |-> mac_be == 4'hf)
    else $error("partial enables before last word");
  a_header_stripped: assert property (@(posedge clk) disable iff (reset) // see R17
    $rose(mac_valid) |-> $past(rst_reg) == R_DATA)
    else $error("word sent outside data phase");
  a_rewind_start: assert property (@(posedge clk) disable iff (reset || reinit) // see R19
    rew && !rel |=> rd_ptr_reg == $past(start_reg) && rst_reg == R_IDLE && !mac_valid)
    else $error("rewind did not return to buffer start");
  a_release_frees: assert property (@(posedge clk) disable iff (reset || reinit) // see R20
    rel |=> start_reg == rd_ptr_reg && start_reg != $past(start_reg))
    else $error("release did not advance the buffer start");
  a_error_halts: assert property (@(posedge clk) disable iff (reset || reinit) // see R21
    chk_fail |=> oos_reg && transmitter_error_flag ##1 rst_reg == R_HALT && !mac_valid)
    else $error("command check failure did not halt");
  a_reserved_err: assert property (@(posedge clk) disable iff (reset) // see R22
    rst_reg == R_CMDB && cmda_reg[31:30] != 2'h0 |=> transmitter_error_flag)
    else $error("reserved bits did not raise error flag");
  a_replace_err: assert property (@(posedge clk) disable iff (reset) // see R23
    rst_reg == R_CMDB && cmda_reg[A_TAGREP] && !cmda_reg[A_TAGINS]
      |=> transmitter_error_flag && oos_reg)
    else $error("replace without insert not flagged");
endmodule : tfx_top
`default_nettype wire

// ---- dv/tfx_mac_model.sv ----
// Stand-in for the MAC transmitter that consumes frames from the extractor.
// Assumes one clock; the bench sets the number of retries asked per frame.
`timescale 1ns/1ps
`default_nettype none
module tfx_mac_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic mac_valid,
  input wire logic [31:0] mac_data,
  input wire logic [3:0] mac_be,
  input wire logic mac_last,
  output logic mac_ready,
  output logic collision_retry_request,
  output logic frame_done_release,
  input wire logic slow, // Toggle ready to stall the stream
  input wire logic [1:0] retries, // Retries owed on the next frame
  output logic [7:0] words, // Words accepted since reset
  output logic [7:0] frames, // Frames released since reset
  output logic [3:0] last_be, // Enables of the latest last word
  output logic [31:0] first_word // First data word ever accepted
);
  logic [1:0] left; // Retries still owed on this frame
  // ************************************
  // Take words, answer each frame end
  // ************************************
  always @(posedge clk)
  begin
    collision_retry_request <= 1'b0;
    frame_done_release <= 1'b0;
    if (reset)
    begin
      mac_ready <= 1'b0;
      words <= 8'h00;
      frames <= 8'h00;
      left <= retries;
    end
    else
    begin
      // Slow mode halves throughput so the stream must hold its word
      mac_ready <= slow ? ~mac_ready : 1'b1;
      if (mac_valid && mac_ready)
      begin
        words <= words + 8'h01;
        if (words == 8'h00)
          first_word <= mac_data;
        if (mac_last && left != 2'h0)
        begin
          collision_retry_request <= 1'b1;
          left <= left - 2'h1;
        end
        else if (mac_last)
        begin
          frame_done_release <= 1'b1;
          frames <= frames + 8'h01;
          left <= retries;
        end
        if (mac_last)
          last_be <= mac_be;
      end
    end
  end
endmodule : tfx_mac_model
`default_nettype wire

// ---- dv/tfx_top_bench.sv ----
// Self-checking bench for the transmit frame extractor.
// Assumes the MAC stand-in answers every frame with a retry or a release.
`timescale 1ns/1ps
`default_nettype none
module tfx_top_bench;
  import tfx_pkg::*;
  logic clk, reset, wr_valid, wr_first, wr_last, wr_ready, mac_valid, mac_last, mac_ready;
  logic collision_retry_request, frame_done_release, opt_valid, igmp_sum_enable;
  logic icmp_sum_enable, segmentation_offload_enable, ip_header_sum_enable, l4_sum_enable;
  logic tag_insert_enable, tag_replace_enable, fcs_pad_enable, tag_cfi;
  logic transmitter_error_flag, reg_wr, reg_rd, slow;
  logic [31:0] wr_data, mac_data, reg_wdata, reg_rdata, first_word;
  logic [3:0] mac_be, reg_addr, last_be;
  logic [19:0] frame_length_field;
  logic [13:0] max_segment_size;
  logic [2:0] tag_priority;
  logic [11:0] tag_vlan_id;
  logic [1:0] retries;
  logic [7:0] words, frames;
  int num_errors, n_checks;
  tfx_top dut_u (.clk, .reset, .wr_valid, .wr_first, .wr_last, .wr_data, .wr_ready,
    .mac_valid, .mac_data, .mac_be, .mac_last, .mac_ready, .collision_retry_request,
    .frame_done_release, .opt_valid, .igmp_sum_enable, .icmp_sum_enable,
    .segmentation_offload_enable, .ip_header_sum_enable, .l4_sum_enable,
    .tag_insert_enable, .tag_replace_enable, .fcs_pad_enable, .frame_length_field,
    .max_segment_size, .tag_priority, .tag_cfi, .tag_vlan_id, .transmitter_error_flag,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  tfx_mac_model mac_u (.clk, .reset, .mac_valid, .mac_data, .mac_be, .mac_last,
    .mac_ready, .collision_retry_request, .frame_done_release, .slow, .retries,
    .words, .frames, .last_be, .first_word);
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // ************************************
  // Access tasks
  // ************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk); // Gap keeps each strobe assigned once per step
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk); // Data stands only in this cycle
    chk(nm, e, reg_rdata);
  endtask : rd
  task put(input logic [31:0] d, input logic f, input logic l);
    wr_data <= d;
    wr_first <= f;
    wr_last <= l;
    wr_valid <= 1'b1;
    @(posedge clk);
    while (wr_ready !== 1'b1) @(posedge clk);
  endtask : put
  task send(input logic [31:0] a, input logic [31:0] b, input int n);
    put(a, 1'b1, 1'b0);
    put(b, 1'b0, n == 0);
    for (int i = 0; i < n; i++) put(32'h5a5a_0000 + 32'(i), 1'b0, i == n - 1);
    wr_valid <= 1'b0;
    @(posedge clk);
  endtask : send
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // Cuts a hang short
  initial
  begin
    #(25 * 20000);
    num_errors++;
    test_done;
  end
  // ************************************
  // Tests
  // ************************************
  initial
  begin
    {clk, wr_valid, wr_first, wr_last, reg_wr, reg_rd, slow} = 7'h00;
    {wr_data, reg_wdata, reg_addr} = 68'h0;
    reset = 1'b1;
    retries = 2'h1;
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    retries <= 2'h0;
    repeat (2) @(posedge clk);
    rd(REG_STATUS, 32'h0, "status");
    rd(4'h2, 32'h0, "unmapped");
    // Tagged 5-byte frame with FCS, retried once, then released
    send(32'h0140_0005, 32'h0000_a123, 2);
    repeat (2) @(posedge clk);
    rd(REG_LEVEL, 32'h5, "level");
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, 32'h1, "ctrl");
    repeat (400) if (opt_valid !== 1'b1) @(posedge clk);
    chk("tag_ins", 1'b1, tag_insert_enable);
    chk("fcs", 1'b1, fcs_pad_enable);
    chk("tag_rep", 1'b0, tag_replace_enable);
    chk("len", 20'h5, frame_length_field);
    chk("tag", {3'h5, 1'b0, 12'h123}, {tag_priority, tag_cfi, tag_vlan_id});
    repeat (400) if (frames !== 8'h01) @(posedge clk);
    @(posedge clk);
    chk("words", 8'h04, words);
    chk("last_be", 4'h1, last_be);
    chk("word0", 32'h5a5a_0000, first_word);
    chk("opt_valid", 1'b0, opt_valid);
    rd(REG_LEVEL, 32'h0, "level");
    // Segmented packet with every checksum request set, MAC stalling
    slow <= 1'b1;
    send(32'h3e40_0006, 32'h0100_0000, 2);
    repeat (400) if (opt_valid !== 1'b1) @(posedge clk);
    chk("seg", 1'b1, segmentation_offload_enable);
    chk("sums", 4'h0, {igmp_sum_enable, icmp_sum_enable, ip_header_sum_enable,
      l4_sum_enable});
    chk("mss", 14'h0100, max_segment_size);
    repeat (400) if (frames !== 8'h02) @(posedge clk);
    @(posedge clk);
    chk("words", 8'h06, words);
    chk("last_be", 4'h3, last_be);
    // Replace without insert: error, nothing forwarded
    slow <= 1'b0;
    send(32'h00c0_0020, 32'h0, 8);
    repeat (400) if (transmitter_error_flag !== 1'b1) @(posedge clk);
    rd(REG_STATUS, 32'h3, "status");
    rd(REG_CAUSE, 32'h80, "cause");
    chk("words", 8'h06, words);
    wr(REG_CTRL, 32'h3);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS, 32'h0, "status");
    // Reserved bits of command A set
    send(32'h4040_0008, 32'h0, 2);
    repeat (400) if (transmitter_error_flag !== 1'b1) @(posedge clk);
    rd(REG_STATUS, 32'h3, "status");
    rd(REG_CAUSE, 32'h100, "cause");
    test_done;
  end
endmodule : tfx_top_bench
`default_nettype wire
